// *** bench/orr_exec_bench.sv ***
// Directed bench for the executor
`default_nettype none
module orr_exec_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in = 0, rstn_in = 0, vld = 0, pop, pl, we, bsy, c;
  logic [11:0] ins = 12'h000;
  logic [8:0]  stk = 9'h123, pcv;
  logic [7:0]  rd = 8'h00, wd, w, opt;
  logic [4:0]  fa;
  int          fails = 0, tests_run = 0, cyc = 0;
  orr_exec dut (.mclk_in, .rstn_in, .instr_valid_in(vld), .instr_in(ins), .stack_top_in(stk),
    .stack_pop_out(pop), .pc_load_out(pl), .pc_value_out(pcv), .busy_out(bsy), .file_addr_out(fa),
    .file_rdata_in(rd), .file_we_out(we), .file_wdata_out(wd), .w_out(w), .option_out(opt), .carry_out(c));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task stop_test;
    if (fails == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task issue(input logic [11:0] i, input logic [7:0] r);
    @(posedge mclk_in);
    vld <= 1'b1;
    ins <= i;
    rd  <= r;
    @(posedge mclk_in);
    vld <= 1'b0;
    #1;
  endtask : issue
  task t_ret;
    @(posedge mclk_in);
    vld <= 1'b1;
    ins <= 12'h8A5;
    #1 chk(pop, 1'b1);
    @(posedge mclk_in);
    ins <= 12'h341;
    rd  <= 8'h01;
    #1 chk(w, 8'hA5);
    chk(pcv, 9'h123);
    chk({pl, bsy}, 2'h3);
    chk(pop, 1'b0);
    @(posedge mclk_in);
    vld <= 1'b0;
    #1 chk({w, pl, bsy}, 10'h294);
  endtask : t_ret
  task t_rot;
    issue(12'h33F, 8'hE7);
    chk({we, fa}, 6'h3F);
    chk({wd, c}, 9'h0E7);
    chk(w, 8'hA5);
    issue(12'h341, 8'hE6);
    chk({w, c}, 9'h19B);
    chk(we, 1'b0);
    chk(fa, 5'h01);
    issue(12'h305, 8'hE6);
    chk({w, c, we}, 10'h3CC);
    issue(12'h36A, 8'h81);
    chk({we, fa}, 6'h2A);
    chk({wd, c, w}, 17'h0_05F3);
  endtask : t_rot
  task t_opt;
    issue(12'h002, 8'h00);
    chk({opt, c}, 9'h1E7);
  endtask : t_opt
  task t_rst;
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    #1 chk({opt, w, c, pl, we, bsy}, 20'hF_F000);
    chk(fa, 5'h02);
    @(posedge mclk_in);
    rstn_in <= 1'b1;
    issue(12'h8C3, 8'h00);
    chk({w, pl, bsy}, 10'h30F);
    chk(pcv, 9'h123);
  endtask : t_rst
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 500) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    #1 chk({opt, w, c}, 17'h1_FE00);
    t_ret();
    t_rot();
    t_opt();
    t_rst();
    stop_test();
  end
endmodule : orr_exec_bench
`default_nettype wire

// *** bench/orr_exec_checker.sv ***
// Port assertions for the executor
`default_nettype none
module orr_exec_checker #(parameter int PC_W = 9) (
  // Clock and reset
  input wire logic            mclk_in,
  input wire logic            rstn_in,
  // Issue, return stack and program counter
  input wire logic            instr_valid_in,
  input wire logic [11:0]     instr_in,
  input wire logic [PC_W-1:0] stack_top_in,
  input wire logic            stack_pop_out,
  input wire logic            pc_load_out,
  input wire logic [PC_W-1:0] pc_value_out,
  input wire logic            busy_out,
  // File port
  input wire logic [4:0]      file_addr_out,
  input wire logic [7:0]      file_rdata_in,
  input wire logic            file_we_out,
  input wire logic [7:0]      file_wdata_out,
  // Architectural state
  input wire logic [7:0]      w_out,
  input wire logic [7:0]      option_out,
  input wire logic            carry_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  wire       iss = instr_valid_in && !busy_out;
  wire       rl  = iss && instr_in[11:6] == 6'h0D;
  wire       rr  = iss && instr_in[11:6] == 6'h0C;
  wire [7:0] rd  = file_rdata_in;
  sequence s_ret; iss && instr_in[11:8] == 4'h8; endsequence
  property p_opt; iss && instr_in == 12'h002 |=> option_out == $past(w_out) && $stable(carry_out); endproperty
  a_opt: assert property (p_opt) else $error("option load");
  property p_ret_w; s_ret |=> w_out == $past(instr_in[7:0]) && $stable(carry_out); endproperty
  a_ret_w: assert property (p_ret_w) else $error("literal");
  property p_pop; s_ret |-> stack_pop_out ##1 pc_load_out && pc_value_out == $past(stack_top_in); endproperty
  a_pop: assert property (p_pop) else $error("stack pop");
  property p_two; s_ret |=> busy_out && !stack_pop_out ##1 !busy_out; endproperty
  a_two: assert property (p_two) else $error("two cycles");
  property p_rl; rl |=> carry_out == $past(rd[7]) && $stable(option_out); endproperty
  a_rl: assert property (p_rl) else $error("left carry");
  property p_rld; rl && !instr_in[5] |=> w_out == {$past(rd[6:0]), $past(carry_out)} && !file_we_out; endproperty
  a_rld: assert property (p_rld) else $error("left dest");
  property p_rrd; rr && instr_in[5] |=> file_we_out && file_wdata_out == {$past(carry_out), $past(rd[7:1])}
    && carry_out == $past(rd[0]); endproperty
  a_rrd: assert property (p_rrd) else $error("right dest");
  property p_addr; (rl || rr) && !file_we_out |-> file_addr_out == instr_in[4:0] ##1 !busy_out; endproperty
  a_addr: assert property (p_addr) else $error("file address");
  property p_rlf; rl && instr_in[5] |=> file_we_out
    && file_wdata_out == {$past(rd[6:0]), $past(carry_out)}; endproperty
  a_rlf: assert property (p_rlf) else $error("left to file");
  property p_rrw; rr && !instr_in[5] |=> w_out == {$past(carry_out), $past(rd[7:1])} && !file_we_out; endproperty
  a_rrw: assert property (p_rrw) else $error("right to W");
  property p_refuse; busy_out |=> $stable(w_out) && $stable(carry_out) && !file_we_out && !pc_load_out; endproperty
  a_refuse: assert property (p_refuse) else $error("busy refuse");
endmodule : orr_exec_checker
bind orr_exec orr_exec_checker #(.PC_W(PC_W)) u_chk (
  .mclk_in        (mclk_in),
  .rstn_in        (rstn_in),
  .instr_valid_in (instr_valid_in),
  .instr_in       (instr_in),
  .stack_top_in   (stack_top_in),
  .stack_pop_out  (stack_pop_out),
  .pc_load_out    (pc_load_out),
  .pc_value_out   (pc_value_out),
  .busy_out       (busy_out),
  .file_addr_out  (file_addr_out),
  .file_rdata_in  (file_rdata_in),
  .file_we_out    (file_we_out),
  .file_wdata_out (file_wdata_out),
  .w_out          (w_out),
  .option_out     (option_out),
  .carry_out      (carry_out)
);
`default_nettype wire

// *** rtl/orr_cfg.svh ***
// Constants for the option/return/rotate execution block
`ifndef ORR_CFG_SVH
`define ORR_CFG_SVH

`define ORR_OP_OPTION     12'h002
`define ORR_RET_HI        4'h8
`define ORR_ROT_HI        4'h3
`define ORR_ROT_LEFT_SEL  2'b01
`define ORR_ROT_RIGHT_SEL 2'b00
`define ORR_DEST_BIT      5
`define ORR_FADDR_MSB     4
`define ORR_RET_CYCLES    2
`define ORR_W_RST         8'h00
`define ORR_OPT_RST       8'hFF
`define ORR_C_RST         1'b0

`endif

// *** rtl/orr_dec_if.sv ***
// Decoded instruction fields passed from decoder to executor
`default_nettype none
interface orr_dec_if;
  import orr_pkg::*;
  orr_op_e    op;
  logic       dest_file;
  logic [4:0] faddr;
  logic [7:0] literal;

  modport dec (output op, output dest_file, output faddr, output literal);
  modport exe (input op, input dest_file, input faddr, input literal);
endinterface : orr_dec_if
`default_nettype wire

// *** rtl/orr_decode.sv ***
// Instruction word decoder for the four handled opcodes
`include "orr_cfg.svh"
`default_nettype none
module orr_decode
  import orr_pkg::*;
(
  // Instruction word
  input  wire logic [11:0] instr_in,
  // Decoded fields
  orr_dec_if.dec           dec
);
  wire is_opt  = (instr_in == `ORR_OP_OPTION);
  wire is_ret  = (instr_in[11:8] == `ORR_RET_HI);
  wire is_rot  = (instr_in[11:8] == `ORR_ROT_HI);
  wire is_rotl = is_rot && (instr_in[7:6] == `ORR_ROT_LEFT_SEL);
  wire is_rotr = is_rot && (instr_in[7:6] == `ORR_ROT_RIGHT_SEL);

  assign dec.op        = is_opt  ? ORR_OP_OPT  :
                         is_ret  ? ORR_OP_RET  :
                         is_rotl ? ORR_OP_ROTL :
                         is_rotr ? ORR_OP_ROTR : ORR_OP_NONE;
  assign dec.dest_file = instr_in[`ORR_DEST_BIT];
  assign dec.faddr     = instr_in[`ORR_FADDR_MSB:0];
  assign dec.literal   = instr_in[7:0];
endmodule : orr_decode
`default_nettype wire

// *** rtl/orr_exec.sv ***
// Execution of option-load, return_with_literal, rotate_left_carry and rotate_right_carry
// Contract
// - Option-load copies W to option, flags kept
// - Return loads low-byte literal into W, flags kept
// - Return pops stack, PC takes stack_top
// - Return takes two instruction cycles
// - Rotate left through carry, carry only flag
// - Rotate left: d selects W or file
// - Rotate right through carry, carry only flag
// - Rotate right: d selects W or file
`include "orr_cfg.svh"
`default_nettype none
module orr_exec
  import orr_pkg::*;
#(
  parameter int PC_W = 9
) (
  // Clock and reset
  input  wire logic            mclk_in,
  input  wire logic            rstn_in,
  // Instruction issue
  input  wire logic            instr_valid_in,
  input  wire logic [11:0]     instr_in,
  // Return stack
  input  wire logic [PC_W-1:0] stack_top_in,
  output logic                 stack_pop_out,
  // Program counter reload
  output logic                 pc_load_out,
  output logic [PC_W-1:0]      pc_value_out,
  output logic                 busy_out,
  // File register port
  output logic [4:0]           file_addr_out,
  input  wire logic [7:0]      file_rdata_in,
  output logic                 file_we_out,
  output logic [7:0]           file_wdata_out,
  // Architectural state
  output logic [7:0]           w_out,
  output logic [7:0]           option_out,
  output logic                 carry_out
);
  ////////////////////////////////////////////////////////////////////////
  orr_dec_if dec_bus ();

  orr_decode u_dec (
    .instr_in (instr_in),
    .dec      (dec_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  orr_state_e state_ff;
  orr_state_e nxt_state;
  logic [7:0]      w_ff;
  logic [7:0]      option_ff;
  logic            carry_ff;
  logic            pc_load_ff;
  logic [PC_W-1:0] pc_value_ff;
  logic            file_we_ff;
  logic [7:0]      file_wdata_ff;
  logic [4:0]      file_addr_ff;

  // Second cycle of a return is a flush slot; no issue accepted
  wire accept  = instr_valid_in && (state_ff == ORR_ST_RUN);
  wire do_opt  = accept && (dec_bus.op == ORR_OP_OPT);
  wire do_ret  = accept && (dec_bus.op == ORR_OP_RET);
  wire do_rotl = accept && (dec_bus.op == ORR_OP_ROTL);
  wire do_rotr = accept && (dec_bus.op == ORR_OP_ROTR);
  wire do_rot  = do_rotl || do_rotr;

  // Rotate through carry, one slice per bit
  // Both directions are formed every cycle; do_rotl picks one
  wire [7:0] rotl_val;
  wire [7:0] rotr_val;

  for (genvar gi = 0; gi < 8; gi++) begin : g_rot
    if (gi == 0) begin : g_lsb
      // Old carry fills the vacated low bit on a left rotate
      assign rotl_val[gi] = carry_ff;
      assign rotr_val[gi] = file_rdata_in[gi+1];
    end else if (gi == 7) begin : g_msb
      // Old carry fills the vacated high bit on a right rotate
      assign rotl_val[gi] = file_rdata_in[gi-1];
      assign rotr_val[gi] = carry_ff;
    end else begin : g_mid
      // Interior bits take their neighbour
      assign rotl_val[gi] = file_rdata_in[gi-1];
      assign rotr_val[gi] = file_rdata_in[gi+1];
    end
  end : g_rot

  // Bit pushed out of the far end becomes the new carry
  wire [7:0] rot_val = do_rotl ? rotl_val : rotr_val;
  wire       rot_cy  = do_rotl ? file_rdata_in[7] : file_rdata_in[0];

  // Destination bit: clear sends the result to W, set to the file
  wire       to_file = dec_bus.dest_file;
  wire       to_w    = !dec_bus.dest_file;

  ////////////////////////////////////////////////////////////////////////
  // Next values; no flag but carry is ever written here
  wire [7:0]      nxt_w          = do_ret ? dec_bus.literal :
                                   (do_rot && to_w) ? rot_val : w_ff;
  wire [7:0]      nxt_option     = do_opt ? w_ff : option_ff;
  wire            nxt_carry      = do_rot ? rot_cy : carry_ff;
  // Pulses and the payloads captured with them
  wire            nxt_pc_load    = do_ret;
  wire [PC_W-1:0] nxt_pc_value   = do_ret ? stack_top_in : pc_value_ff;
  wire            nxt_fwe        = do_rot && to_file;
  wire [7:0]      nxt_file_wdata = do_rot ? rot_val : file_wdata_ff;
  wire [4:0]      nxt_file_addr  = do_rot ? dec_bus.faddr : file_addr_ff;

  // A return holds issue off for one flush cycle
  always_comb begin
    unique case (state_ff)
      ORR_ST_RUN:   nxt_state = do_ret ? ORR_ST_FLUSH : ORR_ST_RUN;
      ORR_ST_FLUSH: nxt_state = ORR_ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= ORR_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Working register
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      w_ff <= `ORR_W_RST;
    end else begin
      w_ff <= nxt_w;
    end
  end

  // Option register
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      option_ff <= `ORR_OPT_RST;
    end else begin
      option_ff <= nxt_option;
    end
  end

  // Carry flag
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      carry_ff <= `ORR_C_RST;
    end else begin
      carry_ff <= nxt_carry;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter reload, one cycle after the return issues
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_load_ff <= 1'b0;
    end else begin
      pc_load_ff <= nxt_pc_load;
    end
  end

  // Return address captured at the issue edge
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_value_ff <= '0;
    end else begin
      pc_value_ff <= nxt_pc_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delayed file write, one cycle after the rotate issues
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      file_we_ff <= 1'b0;
    end else begin
      file_we_ff <= nxt_fwe;
    end
  end

  // Write data held until the next rotate
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      file_wdata_ff <= 8'h00;
    end else begin
      file_wdata_ff <= nxt_file_wdata;
    end
  end

  // Write address held until the next rotate
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      file_addr_ff <= 5'h00;
    end else begin
      file_addr_ff <= nxt_file_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Return stack and program counter
  assign stack_pop_out  = do_ret;
  assign pc_load_out    = pc_load_ff;
  assign pc_value_out   = pc_value_ff;
  assign busy_out       = (state_ff == ORR_ST_FLUSH);

  // File port; a pending write owns the address, so a dependent
  // rotate must be issued one cycle later to read the new value
  assign file_addr_out  = file_we_ff ? file_addr_ff : dec_bus.faddr;
  assign file_we_out    = file_we_ff;
  assign file_wdata_out = file_wdata_ff;

  // Architectural state
  assign w_out          = w_ff;
  assign option_out     = option_ff;
  assign carry_out      = carry_ff;
endmodule : orr_exec
`default_nettype wire

// *** rtl/orr_pkg.sv ***
// Types shared by the execution block
`default_nettype none
package orr_pkg;
  typedef enum logic [2:0] {
    ORR_OP_NONE  = 3'b000,
    ORR_OP_OPT   = 3'b001,
    ORR_OP_RET   = 3'b010,
    ORR_OP_ROTL  = 3'b011,
    ORR_OP_ROTR  = 3'b100
  } orr_op_e;

  typedef enum logic [0:0] {
    ORR_ST_RUN   = 1'b0,
    ORR_ST_FLUSH = 1'b1
  } orr_state_e;
endpackage : orr_pkg
`default_nettype wire
